/* File: rtl/pacn_pkg.sv */
// Package for the port analog-select and change-notify block.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package pacn_pkg;

  // Widths
  localparam int unsigned PORT_W = 16;
  localparam int unsigned CN_W = 23;
  localparam int unsigned CN_LO_W = 16;
  localparam int unsigned CN_HI_W = 7;
  localparam int unsigned ADDR_W = 6;

  // Register byte offsets
  localparam logic [5:0] OFS_DIR_A = 6'h00;
  localparam logic [5:0] OFS_LAT_A = 6'h04;
  localparam logic [5:0] OFS_LVL_A = 6'h08;
  localparam logic [5:0] OFS_ANS_A = 6'h0c;
  localparam logic [5:0] OFS_DIR_B = 6'h10;
  localparam logic [5:0] OFS_LAT_B = 6'h14;
  localparam logic [5:0] OFS_LVL_B = 6'h18;
  localparam logic [5:0] OFS_ANS_B = 6'h1c;
  localparam logic [5:0] OFS_CNEN_LO = 6'h20;
  localparam logic [5:0] OFS_CNEN_HI = 6'h24;
  localparam logic [5:0] OFS_PU_LO = 6'h28;
  localparam logic [5:0] OFS_PU_HI = 6'h2c;
  localparam logic [5:0] OFS_PD_LO = 6'h30;
  localparam logic [5:0] OFS_PD_HI = 6'h34;
  localparam logic [5:0] OFS_CN_STAT = 6'h38;

  // Field positions
  localparam int unsigned CN_FLAG_BIT = 0;

  // Implemented analog-select bits per variant
  localparam logic [15:0] ANS_A_MASK = 16'h000f;
  localparam logic [15:0] ANS_B_MASK_14 = 16'hc010;
  localparam logic [15:0] ANS_B_MASK_20 = 16'hf017;
  localparam logic [15:0] ANS_B_MASK_28 = 16'hf01f;

  // Reset values
  localparam logic [15:0] DIR_RST = 16'hffff;
  localparam logic [15:0] LAT_RST = 16'h0000;
  localparam logic [15:0] ANS_RST = 16'hffff;
  localparam logic [22:0] CN_CFG_RST = 23'h000000;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage : pacn_pkg

/* File: rtl/pacn_sync.sv */
// Two-flop synchroniser for a bus of independent pin levels.
// Assumes each bit is a slow level; no word coherence is promised.
`timescale 1ns/1ps
`default_nettype none
module pacn_sync #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pacn_sync_s;

  pacn_sync_s st_q;
  pacn_sync_s st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d = st_q;
    st_d.meta = async_in;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;

endmodule : pacn_sync
`default_nettype wire

/* File: rtl/pacn_top.sv */
// Port A/B digital I/O with analog select, and input change notification.
// Assumes an AHB-Lite master on clk_sys and pads outside that apply pulls.
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pacn_top #(
  parameter int unsigned PIN_COUNT = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Port A pins
  input wire logic [15:0] port_a_in,
  output logic [15:0] port_a_out,
  output logic [15:0] port_a_oe,
  output logic [15:0] port_a_dig_buf_en,
  // Port B pins
  input wire logic [15:0] port_b_in,
  output logic [15:0] port_b_out,
  output logic [15:0] port_b_oe,
  output logic [15:0] port_b_dig_buf_en,
  // Change notify pins
  input wire logic [22:0] change_notify_in,
  output logic [22:0] weak_pullup_en,
  output logic [22:0] weak_pulldown_en,
  output logic change_notify_irq
);

  localparam logic [15:0] ANS_B_MASK = (PIN_COUNT == 14) ? pacn_pkg::ANS_B_MASK_14 :
                                       (PIN_COUNT == 20) ? pacn_pkg::ANS_B_MASK_20 :
                                       pacn_pkg::ANS_B_MASK_28;

  typedef struct packed {
    logic [15:0] dir_a;
    logic [15:0] dir_b;
    logic [15:0] lat_a;
    logic [15:0] lat_b;
    logic [15:0] ans_a;
    logic [15:0] ans_b;
    logic [22:0] cn_en;
    logic [22:0] pu_en;
    logic [22:0] pd_en;
    logic [22:0] cn_prev;
    logic cn_prev_vld;
    logic cn_flag;
    logic wr_pend;
    logic [5:0] wr_addr;
    logic [31:0] rdata;
  } pacn_state_s;

  pacn_state_s st_q;
  pacn_state_s st_d;

  logic [15:0] pin_a_sync;
  logic [15:0] pin_b_sync;
  logic [22:0] cn_sync;
  logic [15:0] lvl_a;
  logic [15:0] lvl_b;
  logic addr_ok;
  logic cn_event;

  // Pin levels cross into clk_sys before any logic sees them
  pacn_sync #(.W(16)) u_sync_a (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_in(port_a_in),
    .sync_out(pin_a_sync)
  );

  pacn_sync #(.W(16)) u_sync_b (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_in(port_b_in),
    .sync_out(pin_b_sync)
  );

  pacn_sync #(.W(23)) u_sync_cn (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_in(change_notify_in),
    .sync_out(cn_sync)
  );

  // Analog pins read low whatever the pad shows
  assign lvl_a = pin_a_sync & ~st_q.ans_a;
  assign lvl_b = pin_b_sync & ~st_q.ans_b;

  // Word writes merge into a register keeping only implemented bits
  function automatic logic [15:0] merge16(input logic [31:0] wdata, input logic [15:0] mask);
    merge16 = wdata[15:0] & mask;
  endfunction : merge16

  // Read mux shared by all register offsets
  function automatic logic [31:0] read_reg(input logic [5:0] ofs, input pacn_state_s s,
                                           input logic [15:0] la, input logic [15:0] lb);
    read_reg = 32'h0000_0000;
    unique case (ofs)
      pacn_pkg::OFS_DIR_A: read_reg[15:0] = s.dir_a;
      pacn_pkg::OFS_LAT_A: read_reg[15:0] = s.lat_a;
      pacn_pkg::OFS_LVL_A: read_reg[15:0] = la;
      pacn_pkg::OFS_ANS_A: read_reg[15:0] = s.ans_a;
      pacn_pkg::OFS_DIR_B: read_reg[15:0] = s.dir_b;
      pacn_pkg::OFS_LAT_B: read_reg[15:0] = s.lat_b;
      pacn_pkg::OFS_LVL_B: read_reg[15:0] = lb;
      pacn_pkg::OFS_ANS_B: read_reg[15:0] = s.ans_b;
      pacn_pkg::OFS_CNEN_LO: read_reg[15:0] = s.cn_en[15:0];
      pacn_pkg::OFS_CNEN_HI: read_reg[6:0] = s.cn_en[22:16];
      pacn_pkg::OFS_PU_LO: read_reg[15:0] = s.pu_en[15:0];
      pacn_pkg::OFS_PU_HI: read_reg[6:0] = s.pu_en[22:16];
      pacn_pkg::OFS_PD_LO: read_reg[15:0] = s.pd_en[15:0];
      pacn_pkg::OFS_PD_HI: read_reg[6:0] = s.pd_en[22:16];
      pacn_pkg::OFS_CN_STAT: read_reg[pacn_pkg::CN_FLAG_BIT] = s.cn_flag;
      default: read_reg = 32'h0000_0000;
    endcase
  endfunction : read_reg

  assign addr_ok = hsel && hready && (htrans == pacn_pkg::HTRANS_NONSEQ);

  // Any enabled pin that moved since last cycle
  assign cn_event = st_q.cn_prev_vld && (|((cn_sync ^ st_q.cn_prev) & st_q.cn_en));

  always_comb begin
    st_d = st_q;
    // Previous level tracks every pin so enabling a pin never fires on stale data
    st_d.cn_prev = cn_sync;
    st_d.cn_prev_vld = 1'b1;
    // Data phase write
    st_d.wr_pend = 1'b0;
    if (st_q.wr_pend) begin
      unique case (st_q.wr_addr)
        pacn_pkg::OFS_DIR_A: st_d.dir_a = hwdata[15:0];
        pacn_pkg::OFS_LAT_A: st_d.lat_a = hwdata[15:0];
        pacn_pkg::OFS_LVL_A: st_d.lat_a = hwdata[15:0];
        pacn_pkg::OFS_ANS_A: st_d.ans_a = merge16(hwdata, pacn_pkg::ANS_A_MASK);
        pacn_pkg::OFS_DIR_B: st_d.dir_b = hwdata[15:0];
        pacn_pkg::OFS_LAT_B: st_d.lat_b = hwdata[15:0];
        pacn_pkg::OFS_LVL_B: st_d.lat_b = hwdata[15:0];
        pacn_pkg::OFS_ANS_B: st_d.ans_b = merge16(hwdata, ANS_B_MASK);
        pacn_pkg::OFS_CNEN_LO: st_d.cn_en[15:0] = hwdata[15:0];
        pacn_pkg::OFS_CNEN_HI: st_d.cn_en[22:16] = hwdata[6:0];
        pacn_pkg::OFS_PU_LO: st_d.pu_en[15:0] = hwdata[15:0];
        pacn_pkg::OFS_PU_HI: st_d.pu_en[22:16] = hwdata[6:0];
        pacn_pkg::OFS_PD_LO: st_d.pd_en[15:0] = hwdata[15:0];
        pacn_pkg::OFS_PD_HI: st_d.pd_en[22:16] = hwdata[6:0];
        pacn_pkg::OFS_CN_STAT: begin
          if (hwdata[pacn_pkg::CN_FLAG_BIT]) begin
            st_d.cn_flag = 1'b0;
          end
        end
        default: st_d.wr_pend = 1'b0;
      endcase
    end
    // Set after clear so a change in the clearing cycle survives
    if (cn_event) begin
      st_d.cn_flag = 1'b1;
    end
    // Address phase: read data is built now and stands in the data phase
    // Built from the post-write image so a pipelined read-after-write sees new data
    if (addr_ok) begin
      st_d.wr_pend = hwrite;
      st_d.wr_addr = haddr[5:0];
      st_d.rdata = hwrite ? 32'h0000_0000 : read_reg(haddr[5:0], st_d, lvl_a, lvl_b);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q.dir_a <= pacn_pkg::DIR_RST;
      st_q.dir_b <= pacn_pkg::DIR_RST;
      st_q.lat_a <= pacn_pkg::LAT_RST;
      st_q.lat_b <= pacn_pkg::LAT_RST;
      st_q.ans_a <= pacn_pkg::ANS_RST & pacn_pkg::ANS_A_MASK;
      st_q.ans_b <= pacn_pkg::ANS_RST & ANS_B_MASK;
      st_q.cn_en <= pacn_pkg::CN_CFG_RST;
      st_q.pu_en <= pacn_pkg::CN_CFG_RST;
      st_q.pd_en <= pacn_pkg::CN_CFG_RST;
      st_q.cn_prev <= '0;
      st_q.cn_prev_vld <= 1'b0;
      st_q.cn_flag <= 1'b0;
      st_q.wr_pend <= 1'b0;
      st_q.wr_addr <= '0;
      st_q.rdata <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Bus answers every transfer at once with OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_q.rdata;

  // Pads
  assign port_a_out = st_q.lat_a;
  assign port_b_out = st_q.lat_b;
  assign port_a_oe = ~st_q.dir_a;
  assign port_b_oe = ~st_q.dir_b;
  assign port_a_dig_buf_en = ~st_q.ans_a;
  assign port_b_dig_buf_en = ~st_q.ans_b;
  // Both pulls may be on at once if software asks; the pad must tolerate it
  assign weak_pullup_en = st_q.pu_en;
  assign weak_pulldown_en = st_q.pd_en;
  assign change_notify_irq = st_q.cn_flag;

endmodule : pacn_top
`default_nettype wire

/* File: tb/pacn_props.sv */
// Assertions on bus, pin and notify outputs of pacn_top.
// Bound into pacn_top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module pacn_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins
  input wire logic [15:0] port_a_oe,
  input wire logic [15:0] port_b_oe,
  input wire logic [15:0] port_a_dig_buf_en,
  input wire logic [22:0] change_notify_in,
  input wire logic [22:0] weak_pullup_en,
  input wire logic [22:0] weak_pulldown_en,
  input wire logic change_notify_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic dp_q;
  logic [5:0] ofs_q;
  logic [15:0] dir_q;
  wire logic clr = dp_q && ofs_q == pacn_pkg::OFS_CN_STAT && hwdata[0];
  // Write data phase tracker; only direction A data is kept
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dp_q <= 1'b0;
      ofs_q <= 6'h00;
      dir_q <= 16'h0000;
    end else begin
      dp_q <= hsel && hready && hwrite && htrans == pacn_pkg::HTRANS_NONSEQ;
      ofs_q <= haddr[5:0];
      if (dp_q && ofs_q == pacn_pkg::OFS_DIR_A) dir_q <= hwdata[15:0];
    end
  end
  // Synchroniser depth plus compare stays well inside six cycles
  sequence pins_still;
    $stable(change_notify_in) [*6];
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  chk_oe_dir: assert property (dp_q && ofs_q == pacn_pkg::OFS_DIR_A |-> ##[1:2] port_a_oe == ~dir_q)
    else $error("oe not following direction");
  chk_reset_oe: assert property ($rose(nrst) |-> port_a_oe == 16'h0000 && port_b_oe == 16'h0000)
    else $error("pins not inputs after reset");
  chk_reset_pulls: assert property ($rose(nrst) |-> weak_pullup_en == 23'h0 && weak_pulldown_en == 23'h0)
    else $error("pulls on after reset");
  chk_reset_buf: assert property ($rose(nrst) |-> port_a_dig_buf_en == ~pacn_pkg::ANS_A_MASK)
    else $error("analog pin buffer on after reset");
  chk_irq_sticky: assert property (change_notify_irq && !clr |=> change_notify_irq)
    else $error("notify flag dropped");
  chk_irq_cause: assert property (pins_still |=> !$rose(change_notify_irq))
    else $error("notify flag without pin change");
  chk_irq_clear: assert property (pins_still ##0 clr |=> !change_notify_irq)
    else $error("notify flag not cleared");
endmodule : pacn_props
bind pacn_top pacn_props u_props (.*);
`default_nettype wire

/* File: tb/pacn_pins.sv */
// Pin model: port A pads and the notify pins.
// Unpulled, undriven notify pins wander every cycle; undriven port A pads show ext_a.
`timescale 1ns/1ps
`default_nettype none
module pacn_pins (
  // Clock
  input wire logic clk_sys,
  // From the block
  input wire logic [15:0] port_a_out,
  input wire logic [15:0] port_a_oe,
  input wire logic [22:0] weak_pullup_en,
  input wire logic [22:0] weak_pulldown_en,
  // From the bench
  input wire logic [15:0] ext_a,
  input wire logic [22:0] drv,
  input wire logic [22:0] drv_en,
  // To the block
  output logic [15:0] port_a_in,
  output logic [22:0] change_notify_in
);
  logic [22:0] flt_q = 23'h2aaaaa;
  always @(posedge clk_sys) flt_q <= ~flt_q;
  // Driven pad shows its own level
  assign port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & ext_a);
  assign change_notify_in = (drv_en & drv) | (~drv_en & (weak_pullup_en | (~weak_pulldown_en & flt_q)));
endmodule : pacn_pins
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for pacn_top with PIN_COUNT 20.
// Assumes one AHB-Lite master and the pin model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [15:0] ext_a = '0;
  logic [15:0] port_b_in = '0;
  logic [22:0] drv = '0;
  logic [22:0] drv_en = '0;
  logic [31:0] rd;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  wire logic hready;
  wire logic [31:0] hrdata;
  wire logic [15:0] pa_in, pa_out, pa_oe, pa_buf, pb_buf, pb_out, pb_oe;
  wire logic [22:0] cn_in, pu, pd;
  wire logic irq;
  always #12.5 clk_sys = ~clk_sys;
  pacn_top #(.PIN_COUNT(20)) dut (.clk_sys(clk_sys), .nrst(nrst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(pacn_pkg::HSIZE_WORD), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(), .port_a_in(pa_in), .port_a_out(pa_out), .port_a_oe(pa_oe),
    .port_a_dig_buf_en(pa_buf), .port_b_in(port_b_in), .port_b_out(pb_out), .port_b_oe(pb_oe),
    .port_b_dig_buf_en(pb_buf), .change_notify_in(cn_in), .weak_pullup_en(pu), .weak_pulldown_en(pd),
    .change_notify_irq(irq));
  pacn_pins u_pins (.clk_sys(clk_sys), .port_a_out(pa_out), .port_a_oe(pa_oe), .weak_pullup_en(pu),
    .weak_pulldown_en(pd), .ext_a(ext_a), .drv(drv), .drv_en(drv_en), .port_a_in(pa_in), .change_notify_in(cn_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // No fixed latency assumed; the global timeout ends a stuck wait
  task automatic xfer(input logic [5:0] a, input logic w, input logic [31:0] d);
    haddr <= {26'h0, a};
    hwrite <= w;
    htrans <= pacn_pkg::HTRANS_NONSEQ;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic rdx(input logic [5:0] a, input logic [31:0] exp, input string m);
    xfer(a, 1'b0, 32'h0);
    chk(rd, exp, m);
  endtask : rdx
  task automatic summarize();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      summarize();
    end
  end
  task automatic t_reset();
    chk(pa_buf, {16'h0, ~pacn_pkg::ANS_A_MASK}, "buf A");
    chk(pb_buf, {16'h0, ~pacn_pkg::ANS_B_MASK_20}, "buf B");
    rdx(pacn_pkg::OFS_DIR_A, 32'hffff, "dir");
    rdx(pacn_pkg::OFS_ANS_A, {16'h0, pacn_pkg::ANS_A_MASK}, "ans A");
    rdx(pacn_pkg::OFS_ANS_B, {16'h0, pacn_pkg::ANS_B_MASK_20}, "ans B");
    for (int a = 32; a <= 60; a += 4) rdx(6'(a), 32'h0, "cfg zero");
    $display("reset test done");
  endtask : t_reset
  task automatic t_ans();
    xfer(pacn_pkg::OFS_ANS_A, 1'b1, 32'hffffffff);
    rdx(pacn_pkg::OFS_ANS_A, {16'h0, pacn_pkg::ANS_A_MASK}, "ans A bits");
    xfer(pacn_pkg::OFS_ANS_B, 1'b1, 32'h0);
    rdx(pacn_pkg::OFS_ANS_B, 32'h0, "ans B clr");
    chk(pb_buf, 32'hffff, "buf B on");
    $display("analog test done");
  endtask : t_ans
  task automatic t_level();
    ext_a <= 16'h00a5;
    xfer(pacn_pkg::OFS_ANS_A, 1'b1, 32'h3);
    repeat (2) @(posedge clk_sys);
    rdx(pacn_pkg::OFS_LVL_A, 32'h00a4, "analog low");
    xfer(pacn_pkg::OFS_DIR_A, 1'b1, 32'hff00);
    xfer(pacn_pkg::OFS_LAT_A, 1'b1, 32'h5a);
    chk(pa_oe, 32'h00ff, "oe");
    repeat (3) @(posedge clk_sys);
    chk(pa_out, 32'h005a, "out");
    rdx(pacn_pkg::OFS_LAT_A, 32'h5a, "latch");
    rdx(pacn_pkg::OFS_LVL_A, 32'h58, "level");
    $display("level test done");
  endtask : t_level
  task automatic t_portb();
    port_b_in <= 16'h1234;
    xfer(pacn_pkg::OFS_DIR_B, 1'b1, 32'h00ff);
    xfer(pacn_pkg::OFS_LAT_B, 1'b1, 32'habcd);
    @(posedge clk_sys);
    chk(pb_oe, 32'hff00, "oe B");
    chk(pb_out, 32'habcd, "out B");
    rdx(pacn_pkg::OFS_LVL_B, 32'h1234, "level B");
    xfer(pacn_pkg::OFS_ANS_B, 1'b1, 32'hffff);
    rdx(pacn_pkg::OFS_LVL_B, {16'h0, 16'h1234 & ~pacn_pkg::ANS_B_MASK_20}, "level B analog");
    $display("port B test done");
  endtask : t_portb
  task automatic t_notify();
    // Idle notify pins held still so the checker sees quiet windows
    drv_en <= 23'h40fffc;
    xfer(pacn_pkg::OFS_PU_LO, 1'b1, 32'h1);
    xfer(pacn_pkg::OFS_PU_HI, 1'b1, 32'h7f);
    xfer(pacn_pkg::OFS_PD_LO, 1'b1, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk(pu, 32'h7f0001, "pull-up");
    chk(pd, 32'h2, "pull-down");
    xfer(pacn_pkg::OFS_CNEN_LO, 1'b1, 32'h13);
    xfer(pacn_pkg::OFS_CNEN_HI, 1'b1, 32'h40);
    repeat (6) @(posedge clk_sys);
    xfer(pacn_pkg::OFS_CN_STAT, 1'b1, 32'h1);
    rdx(pacn_pkg::OFS_CN_STAT, 32'h0, "quiet");
    drv <= 23'h20;
    repeat (6) @(posedge clk_sys);
    chk(irq, 32'h0, "masked pin");
    drv <= 23'h30;
    repeat (6) @(posedge clk_sys);
    chk(irq, 32'h1, "enabled pin");
    xfer(pacn_pkg::OFS_CN_STAT, 1'b1, 32'h0);
    @(posedge clk_sys);
    chk(irq, 32'h1, "write zero");
    xfer(pacn_pkg::OFS_CN_STAT, 1'b1, 32'h1);
    rdx(pacn_pkg::OFS_CN_STAT, 32'h0, "cleared");
    drv <= 23'h400030;
    repeat (6) @(posedge clk_sys);
    chk(irq, 32'h1, "high pin");
    $display("notify test done");
  endtask : t_notify
  initial begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_ans();
    t_level();
    t_portb();
    t_notify();
    summarize();
  end
endmodule : testbench
`default_nettype wire
